// file: rtl/mfr_status_pkg.sv
`default_nettype none
package mfr_status_pkg;
  // command codes on the command port
  localparam logic [7:0] CMD_VENDOR_FAULT_STATUS = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8b;
  localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
  localparam logic [7:0] PHASE_ALL = 8'hff;
  // vendor status bit positions
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_SELF_CHECK = 6;
  localparam int BIT_OUT_RESET = 3;
  localparam int BIT_BACKCHANNEL = 2;
  localparam int BIT_SYNC = 1;
  localparam logic [7:0] LATCHED_MASK = 8'h8e;
  localparam int BIT_INVALID_CMD = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int PHASES = 4;

  // one bus transaction as decoded by the serial front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
  } cmd_req_t;

  // one-cycle hardware fault events
  typedef struct packed {
    logic powerOnBad;
    logic outReset;
    logic backchannel;
    logic syncFault;
  } fault_evt_t;
endpackage
`default_nettype wire

// file: rtl/mfr_status_and_telemetry_regs.sv
// Overview of operation
// - fault-clear command clears all latched vendor flags; writing 1 clears one flag.
// - bit 7 latches on bad trim check, config checksum or strap detection.
// - bit 6 is live: 1 during self-check or while followers are silent.
// - bits 5:4 and 0 always read zero and ignore writes.
// - bit 3 latches output reset event, bit 2 back-channel fault; write-1 clears.
// - bit 1 latches sync fault; resets to 0, write-1 clears.
// - each alert-capable vendor bit has an alert mask bit.
// - input voltage word is read-only, exponent 15:11, mantissa 10:0.
// - write to read-only telemetry sets comm fault, invalid-command bit, alert.
// - phase FFh selects the lead controller's input voltage.
// - other phases select that phase's device input voltage.
// - output voltage word is read-only, 16 bits, per output format.
// - as loop follower report raw sense voltage, ignoring divider ratio.
// - summary comm fault bit is the OR of comm status flags.
`default_nettype none
module mfr_status_and_telemetry_regs
  import mfr_status_pkg::*;
#(
  parameter int NUM_PHASES = PHASES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // decoded bus commands
  input wire cmd_req_t cmdReq,
  input wire logic [7:0] phaseSel,
  // hardware events and live status, asynchronous to this clock
  input wire fault_evt_t faultEvt,
  input wire logic selfCheckBusy,
  input wire logic followersMissing,
  // alert mask for vendor status
  input wire logic [7:0] alertMask,
  // measurements
  input wire logic [15:0] leadInputVoltage,
  input wire logic [NUM_PHASES*16-1:0] phaseInputVoltage,
  input wire logic [15:0] scaledOutputVoltage,
  input wire logic [15:0] rawSenseVoltage,
  input wire logic loopFollower,
  // answers
  output logic [15:0] readData,
  output logic [7:0] vendorStatus,
  output logic [7:0] commStatus,
  output logic commFaultSummary,
  output logic alertReq
);

  // ****************************************
  // parameter check
  // ****************************************
  // phase code FFh stands for the whole stack, so it cannot name a single phase
  if (NUM_PHASES < 1 || NUM_PHASES > int'(PHASE_ALL)) begin
    $error("NUM_PHASES out of range");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [5:0] syncA_reg, syncB_reg;
  logic [5:0] syncA_next, syncB_next;
  logic [5:0] evtPrev_reg, evtPrev_next;
  // two stages before any logic reads a pin; the third stage only feeds edge detection

  always_comb begin
    syncA_next = {faultEvt, selfCheckBusy, followersMissing};
    syncB_next = syncA_reg;
    evtPrev_next = syncB_reg;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= 6'h00;
      syncB_reg <= 6'h00;
      evtPrev_reg <= 6'h00;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      evtPrev_reg <= evtPrev_next;
    end
  end

  // rising edges only, so a held event level latches once; the level must
  // fall and rise again before a cleared flag can be set anew
  fault_evt_t evtRise;
  assign evtRise = syncB_reg[5:2] & ~evtPrev_reg[5:2];

  // ****************************************
  // status flags
  // ****************************************
  logic [7:0] latched_reg, latched_next;
  logic [7:0] comm_reg, comm_next;
  logic [7:0] vstat_reg, vstat_next;
  logic alert_reg, alert_next;
  logic summary_reg, summary_next;
  logic isWrite, isRead, isRoWrite, isClear;
  logic [7:0] setMask, clrMask;

  function automatic logic [15:0] pick_phase(input logic [7:0] ph,
                                             input logic [NUM_PHASES*16-1:0] all);
    logic [15:0] v;
    v = WORD_RESET;
    for (int i = 0; i < NUM_PHASES; i++) begin
      if (ph == 8'(i)) begin
        v = all[i*16 +: 16];
      end
    end
    return v;
  endfunction

  // true when a taken command carries the given code
  function automatic logic cmd_is(input cmd_req_t req, input logic [7:0] code);
    return req.valid && (req.code == code);
  endfunction

  // ****************************************
  // command decode
  // ****************************************
  // decoding is shared by the flag and read paths
  always_comb begin
    isWrite = cmdReq.valid && cmdReq.write;
    isRead = cmdReq.valid && !cmdReq.write;
    // the clear command carries no data, so its direction bit is not looked at
    isClear = cmd_is(cmdReq, CMD_FAULT_CLEAR);
    isRoWrite = isWrite && (cmd_is(cmdReq, CMD_INPUT_VOLTAGE) ||
                            cmd_is(cmdReq, CMD_OUTPUT_VOLTAGE));
  end

  // ****************************************
  // flag update
  // ****************************************
  always_comb begin
    setMask = STATUS_RESET;
    setMask[BIT_POWER_ON] = evtRise.powerOnBad;
    setMask[BIT_OUT_RESET] = evtRise.outReset;
    setMask[BIT_BACKCHANNEL] = evtRise.backchannel;
    setMask[BIT_SYNC] = evtRise.syncFault;
    clrMask = STATUS_RESET;
    if (isClear) begin
      clrMask = LATCHED_MASK;
    end else if (isWrite && cmd_is(cmdReq, CMD_VENDOR_FAULT_STATUS)) begin
      clrMask = cmdReq.data & LATCHED_MASK;
    end
    // a set in the same cycle as its clear wins
    latched_next = ((latched_reg & ~clrMask) | setMask) & LATCHED_MASK;
    comm_next = comm_reg;
    if (isClear) begin
      comm_next = STATUS_RESET;
    end
    // an invalid write in the clear cycle still leaves its flag set
    if (isRoWrite) begin
      comm_next[BIT_INVALID_CMD] = 1'b1;
    end
    // loaded from the same next value as the comm flags, so both agree every cycle
    summary_next = |comm_next;
    // bit 6 is live: it follows the synced levels and is never latched
    vstat_next = latched_next;
    vstat_next[BIT_SELF_CHECK] = syncB_reg[1] | syncB_reg[0];
    // latched flags raise the alert, each gated by its mask bit; any comm flag raises it unmasked
    alert_next = |(latched_next & ~alertMask) | (|comm_next);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latched_reg <= STATUS_RESET;
      comm_reg <= STATUS_RESET;
      vstat_reg <= STATUS_RESET;
      alert_reg <= 1'b0;
      summary_reg <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      comm_reg <= comm_next;
      vstat_reg <= vstat_next;
      alert_reg <= alert_next;
      summary_reg <= summary_next;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // a vendor status read returns the registered view, one cycle behind a flag change
  logic [15:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (isRead) begin
      if (cmd_is(cmdReq, CMD_VENDOR_FAULT_STATUS)) begin
        rdata_next = {STATUS_RESET, vstat_reg};
      end else if (cmd_is(cmdReq, CMD_INPUT_VOLTAGE)) begin
        if (phaseSel == PHASE_ALL) begin
          rdata_next = leadInputVoltage;
        end else begin
          // phase codes with no device behind them read zero
          rdata_next = pick_phase(phaseSel, phaseInputVoltage);
        end
      end else if (cmd_is(cmdReq, CMD_OUTPUT_VOLTAGE)) begin
        // a loop follower reports its raw sense voltage, unscaled by the divider ratio
        rdata_next = loopFollower ? rawSenseVoltage : scaledOutputVoltage;
      end else begin
        // codes this block does not serve read as zero
        rdata_next = WORD_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= WORD_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a register, so no decode glitch reaches the bus side
  assign readData = rdata_reg;
  assign vendorStatus = vstat_reg;
  assign commStatus = comm_reg;
  assign commFaultSummary = summary_reg;
  assign alertReq = alert_reg;

endmodule
`default_nettype wire

// file: dv/mfr_status_sva.sv
`default_nettype none
module mfr_status_sva
  import mfr_status_pkg::*;
(
  // bus side
  input wire logic clk_sys,
  input wire logic nrst,
  input wire cmd_req_t cmdReq,
  input wire logic [7:0] phaseSel,
  input wire logic [15:0] leadInputVoltage,
  input wire fault_evt_t faultEvt,
  // answers
  input wire logic [15:0] readData,
  input wire logic [7:0] vendorStatus,
  input wire logic [7:0] commStatus,
  input wire logic commFaultSummary,
  input wire logic alertReq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr;
  logic rd;
  assign wr = cmdReq.valid && cmdReq.write;
  assign rd = cmdReq.valid && !cmdReq.write;
  a_summary_or: assert property (commFaultSummary == |commStatus)
    else $error("bad summary");
  a_unused_zero: assert property (vendorStatus[5:4] == 2'b00 && !vendorStatus[0])
    else $error("unused bit set");
  a_vin_write_flag: assert property (wr && cmdReq.code == CMD_INPUT_VOLTAGE
    |=> commStatus[BIT_INVALID_CMD]) else $error("no invalid flag");
  a_vout_write_alert: assert property (wr && cmdReq.code == CMD_OUTPUT_VOLTAGE
    |=> alertReq && commFaultSummary) else $error("no alert");
  a_lead_read: assert property (rd && cmdReq.code == CMD_INPUT_VOLTAGE
    && phaseSel == PHASE_ALL |=> readData == $past(leadInputVoltage))
    else $error("bad lead read");
  // an event edge reaching the flags in the clear cycle wins over the clear
  a_clear_all: assert property (wr && cmdReq.code == CMD_FAULT_CLEAR
    && ($past(faultEvt, 2) & ~$past(faultEvt, 3)) == 4'h0
    |=> (vendorStatus & LATCHED_MASK) == 8'h00) else $error("clear failed");
  a_write_one: assert property (wr && cmdReq.code == CMD_VENDOR_FAULT_STATUS
    && ($past(faultEvt, 2) & ~$past(faultEvt, 3)) == 4'h0
    |=> (vendorStatus & $past(cmdReq.data) & LATCHED_MASK) == 8'h00)
    else $error("w1c failed");
  a_write_keep: assert property (wr && cmdReq.code == CMD_VENDOR_FAULT_STATUS
    |=> ($past(vendorStatus) & ~vendorStatus & ~$past(cmdReq.data) & LATCHED_MASK) == 8'h00)
    else $error("flag lost");
  c_clear: cover property (wr && cmdReq.code == CMD_FAULT_CLEAR);
  c_read: cover property (rd && cmdReq.code == CMD_OUTPUT_VOLTAGE);
  c_alert: cover property (alertReq && vendorStatus[BIT_SYNC]);
endmodule
bind mfr_status_and_telemetry_regs mfr_status_sva u_mfr_status_sva (.clk_sys(clk_sys),
  .nrst(nrst), .cmdReq(cmdReq), .phaseSel(phaseSel), .leadInputVoltage(leadInputVoltage),
  .faultEvt(faultEvt), .readData(readData), .vendorStatus(vendorStatus),
  .commStatus(commStatus), .commFaultSummary(commFaultSummary), .alertReq(alertReq));
`default_nettype wire

// file: dv/host_model.sv
`default_nettype none
module host_model
  import mfr_status_pkg::*;
(
  // bus side
  input wire logic clk_sys,
  output var cmd_req_t cmdReq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmdReq = '0;
  // one command, valid for exactly one taking edge
  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_sys) cmdReq <= '{1'b1, w, c, d};
    @(posedge clk_sys) cmdReq <= '0;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import mfr_status_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, nrst = 0, selfCheckBusy = 0, followersMissing = 0, loopFollower = 0;
  logic [7:0] phaseSel = 8'hff, alertMask = 8'h00, vendorStatus, commStatus;
  fault_evt_t faultEvt = '0;
  cmd_req_t cmdReq;
  logic [15:0] readData;
  logic commFaultSummary, alertReq;
  int n_errors = 0, comparisons = 0;
  // code, phase, follower, expected word
  logic [32:0] rows [8] = '{{8'h88, 8'hff, 1'b0, 16'h1234}, {8'h88, 8'h02, 1'b0, 16'h3333},
    {8'h80, 8'hff, 1'b0, 16'h0000}, {8'h88, 8'h01, 1'b0, 16'h2222},
    {8'h88, 8'h07, 1'b0, 16'h0000}, {8'h8b, 8'h01, 1'b0, 16'h5678},
    {8'h8c, 8'hff, 1'b0, 16'h0000}, {8'h8b, 8'hff, 1'b1, 16'h00ab}};
  host_model u_host_model (.clk_sys(clk_sys), .cmdReq(cmdReq));
  mfr_status_and_telemetry_regs u_mfr_status_and_telemetry_regs (.clk_sys(clk_sys),
    .nrst(nrst), .cmdReq(cmdReq), .phaseSel(phaseSel), .faultEvt(faultEvt),
    .selfCheckBusy(selfCheckBusy), .followersMissing(followersMissing), .alertMask(alertMask),
    .leadInputVoltage(16'h1234), .phaseInputVoltage(64'h4444_3333_2222_1111),
    .scaledOutputVoltage(16'h5678), .rawSenseVoltage(16'h00ab), .loopFollower(loopFollower),
    .readData(readData), .vendorStatus(vendorStatus), .commStatus(commStatus),
    .commFaultSummary(commFaultSummary), .alertReq(alertReq));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // events pass a two-stage synchroniser, so allow a few edges
  task automatic pulse(input fault_evt_t e);
    @(posedge clk_sys) faultEvt <= e;
    @(posedge clk_sys) faultEvt <= '0;
    tick(5);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    tick(20);
    `CHK({vendorStatus, commStatus, readData, alertReq}, 33'h0)
    nrst <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      phaseSel <= rows[i][24:17];
      loopFollower <= rows[i][16];
      u_host_model.send(1'b0, rows[i][32:25], 8'h00);
      tick(2);
      `CHK(readData, rows[i][15:0])
    end
    pulse('{1'b0, 1'b0, 1'b0, 1'b1});
    `CHK({vendorStatus, alertReq}, 9'h005)
    u_host_model.send(1'b0, CMD_VENDOR_FAULT_STATUS, 8'h00);
    tick(2);
    `CHK(readData, 16'h0002)
    u_host_model.send(1'b1, CMD_VENDOR_FAULT_STATUS, 8'h71);
    tick(2);
    `CHK(vendorStatus, 8'h02)
    u_host_model.send(1'b1, CMD_VENDOR_FAULT_STATUS, 8'h02);
    tick(2);
    `CHK(vendorStatus, 8'h00)
    alertMask <= LATCHED_MASK;
    selfCheckBusy <= 1'b1;
    pulse('1);
    `CHK({vendorStatus, alertReq}, 9'h19c)
    u_host_model.send(1'b1, CMD_FAULT_CLEAR, 8'h00);
    selfCheckBusy <= 1'b0;
    followersMissing <= 1'b1;
    tick(5);
    `CHK(vendorStatus, 8'h40)
    u_host_model.send(1'b1, CMD_INPUT_VOLTAGE, 8'h55);
    tick(2);
    `CHK({commStatus, commFaultSummary, alertReq, readData}, {10'h203, 16'h0002})
    u_host_model.send(1'b1, CMD_FAULT_CLEAR, 8'h00);
    tick(2);
    `CHK({commStatus, commFaultSummary}, 9'h000)
    // reset in mid-run clears latched flags; the live bit returns after the synchroniser
    pulse('{1'b0, 1'b0, 1'b0, 1'b1});
    `CHK(vendorStatus, 8'h42)
    nrst <= 1'b0;
    tick(2);
    `CHK({vendorStatus, commStatus, readData, alertReq}, 33'h0)
    nrst <= 1'b1;
    tick(4);
    `CHK({vendorStatus, alertReq}, 9'h080)
    tally_and_finish;
  end
endmodule
`default_nettype wire
